// [hw/rsq_reset_seq.sv]
`timescale 1ns/10ps
// Operation
// - Reference is main clock (host) or bus clock (agent).
// - Driven hard/soft reset held 512 sync periods.
// - Soft released 16 sync periods after hard.
// - Stop driving config pins when hard asserts.
// - Resume config pins one sync period later.
// - Straps are three-bit source plus divider bit.
// - Host sync period follows strapped input divider.
// - DLL lock wait 7680 to 122880 bus cycles.
// - Hard and soft reset pins are open drain.
// - Bus clock derived from main clock by PLL ratio.
// - General pins high impedance while power-on reset asserted.
module rsq_reset_seq
	import rsq_pkg::*;
(
	input  wire logic       clk_sys_i,              // System clock, 40 MHz.
	input  wire logic       rst_n_i,                // Asynchronous reset, active low.
	input  wire logic       host_mode_i,            // High in bus host mode.
	input  wire logic       main_clock_in_i,        // Main input clock, sampled.
	input  wire logic       bus_clock_in_i,         // Bus sync clock, sampled.
	input  wire logic       power_on_reset_n_i,     // Power-on reset, active low.
	input  wire logic       hard_reset_n_i,         // Hard reset pin level.
	input  wire logic       soft_reset_n_i,         // Soft reset pin level.
	input  wire logic [2:0] strap_reset_source_i,   // Reset source strap.
	input  wire logic       strap_input_divider_i,  // Input divider strap.
	input  wire logic [3:0] pll_ratio_i,            // System PLL ratio.
	input  wire logic [3:0] dll_ratio_i,            // Output to bus clock ratio.
	output logic            hard_reset_n_o,         // Hard reset pin drive value.
	output logic            hard_reset_oe_o,        // Hard reset pin enable.
	output logic            soft_reset_n_o,         // Soft reset pin drive value.
	output logic            soft_reset_oe_o,        // Soft reset pin enable.
	output logic            cfg_oe_o,               // Shared config pins enable.
	output logic            io_hiz_o,               // Hold general pins floating.
	output logic [2:0]      strap_reset_source_o,   // Captured source strap.
	output logic            strap_input_divider_o,  // Captured divider strap.
	output logic            ready_o                 // Sequence complete.
);

	// ****************************************************************
	// Reset release
	// ****************************************************************

	logic rst_meta_q; // First synchroniser stage.
	logic rst_sync_q; // Released reset used everywhere.

	// Assertion is immediate, release takes two edges to avoid metastability.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// DLL lock wait for a clamped ratio; 2 gives the least, 8 the most.
	function automatic logic [CNT_W-1:0] dll_wait(input logic [3:0] r);
		logic [3:0] c;
		c = r;
		if (c < DLL_RATIO_MIN)
			c = DLL_RATIO_MIN;
		if (c > DLL_RATIO_MAX)
			c = DLL_RATIO_MAX;
		return CNT_W'(DLL_BASE * c * c);
	endfunction

	rsq_regs_t        q;          // Registered state.
	rsq_regs_t        d;          // Next state.
	logic             main_rise;  // Main clock rising edge seen.
	logic             bus_rise;   // Bus clock rising edge seen.
	logic             sync_tick;  // One bus sync period elapsed.
	logic             hard_drive; // Device pulls hard reset low.
	logic             soft_drive; // Device pulls soft reset low.
	logic [CNT_W-1:0] dll_end;    // DLL lock wait target.

	// ****************************************************************
	// Reference clock selection
	// ****************************************************************

	// Inputs are synchronous, so the previous sample is enough for edges.
	// The sync period comes from the main clock through the strapped
	// divider in host mode and straight from the bus clock in agent mode.
	always_comb
	begin
		main_rise = main_clock_in_i & ~q.main_q;
		bus_rise  = bus_clock_in_i & ~q.bus_q;
		if (host_mode_i)
			sync_tick = main_rise & (~q.div_q | q.div_ph);
		else
			sync_tick = bus_rise;
		dll_end = dll_wait(dll_ratio_i);
	end

	// Pin ownership follows the state only.
	always_comb
	begin
		hard_drive = (q.st == ST_POR) | (q.st == ST_PLL) |
			(q.st == ST_DLL) | (q.st == ST_HARD);
		soft_drive = hard_drive | (q.st == ST_SOFT) | (q.st == ST_SRST);
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************

	// Next-state logic. The PLL, DLL, HARD, SOFT and SRST steps wait on the shared counter, cleared on entry.
	always_comb
	begin
		d = q;
		d.main_q = main_clock_in_i;
		d.bus_q  = bus_clock_in_i;
		// The divider phase runs on every main edge, whatever the state.
		if (main_rise)
			d.div_ph = ~q.div_ph;
		case (q.st)
			ST_POR:
			begin
				// Straps are followed while power-on is held and frozen at release.
				d.cnt   = '0;
				d.src_q = strap_reset_source_i;
				d.div_q = strap_input_divider_i;
				if (power_on_reset_n_i)
					d.st = ST_PLL;
			end
			ST_PLL:
			begin
				// No lock indication exists, so the worst case is waited out.
				d.cnt = q.cnt + 17'h00001;
				if (q.cnt == PLL_LOCK_END)
				begin
					d.cnt = '0;
					d.st  = ST_DLL;
				end
			end
			ST_DLL:
			begin
				// One main period is pll_ratio bus cycles.
				if (main_rise)
					d.cnt = q.cnt + CNT_W'(pll_ratio_i);
				if (q.cnt >= dll_end)
				begin
					d.cnt = '0;
					d.st  = ST_HARD;
				end
			end
			ST_HARD:
			begin
				if (sync_tick)
				begin
					d.cnt = q.cnt + 17'h00001;
					if (q.cnt == HARD_HOLD_TICKS - 17'h00001)
					begin
						d.cnt = '0;
						d.st  = ST_SOFT;
					end
				end
			end
			ST_SOFT:
			begin
				// Hard is released here; soft stays low for the gap.
				if (sync_tick)
				begin
					d.cnt = q.cnt + 17'h00001;
					if (q.cnt == CFG_RESUME_TICKS - 17'h00001)
						d.cfg_en = 1'b1;
					if (q.cnt == SOFT_GAP_TICKS - 17'h00001)
					begin
						d.cnt = '0;
						d.st  = ST_RUN;
					end
				end
			end
			ST_SRST:
			begin
				// Soft-only reset keeps the configuration pins alive.
				if (sync_tick)
				begin
					d.cnt = q.cnt + 17'h00001;
					if (q.cnt == HARD_HOLD_TICKS - 17'h00001)
					begin
						d.cnt = '0;
						d.st  = ST_RUN;
					end
				end
			end
			ST_RUN:
			begin
				// A short glitch on a pin does not start a reset flow.
				if (!hard_reset_n_i || !soft_reset_n_i)
				begin
					if (sync_tick)
						d.ext = q.ext + 6'h01;
					if (sync_tick && q.ext == EXT_REQ_TICKS - 6'h01)
					begin
						d.ext = '0;
						d.cnt = '0;
						if (!hard_reset_n_i)
						begin
							d.st     = ST_HARD;
							d.cfg_en = 1'b0;
						end
						else
							d.st = ST_SRST;
					end
				end
				else
					d.ext = '0;
			end
			default:
			begin
				d.st = ST_POR;
			end
		endcase
		// Power-on reset overrides every step.
		if (!power_on_reset_n_i)
		begin
			d.st     = ST_POR;
			d.cfg_en = 1'b0;
			d.ext    = '0;
		end
	end

	// State register.
	always_ff @(posedge clk_sys_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			q    <= '0;
			q.st <= ST_POR;
		end
		else
			q <= d;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Reset pins only ever pull low; the board pull-up makes the high level.
	assign hard_reset_n_o  = 1'b0;
	assign hard_reset_oe_o = hard_drive;
	assign soft_reset_n_o  = 1'b0;
	assign soft_reset_oe_o = soft_drive;
	// The pin level gates the enable directly, so turn-off needs no clock edge.
	assign cfg_oe_o = q.cfg_en & hard_reset_n_i & ~hard_drive;
	assign io_hiz_o = ~power_on_reset_n_i | (q.st == ST_POR);
	assign strap_reset_source_o  = q.src_q;
	assign strap_input_divider_o = q.div_q;
	assign ready_o = (q.st == ST_RUN);

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_sync_q);

	// The reset pins are never driven high.
	open_drain_a: assert property (!hard_reset_n_o && !soft_reset_n_o)
		else $error("reset pin driven high");

	// Hard release only after the full hold count on a sync tick.
	hard_hold_a: assert property ((q.st == ST_HARD) && (d.st == ST_SOFT) |->
		sync_tick && (q.cnt == 17'h001FF))
		else $error("hard reset released early");

	// Soft release waits sixteen sync ticks after hard release.
	soft_gap_a: assert property ((q.st == ST_SOFT) && (d.st == ST_RUN) |->
		sync_tick && (q.cnt == 17'h0000F) && !hard_drive)
		else $error("soft reset released early");

	// Config pins float whenever the hard reset pin is low.
	cfg_off_a: assert property (!hard_reset_n_i |-> !cfg_oe_o)
		else $error("config pins driven in hard reset");

	// Config drive resumes on the first sync tick after hard release.
	cfg_on_a: assert property ($rose(q.cfg_en) |->
		$past(q.st == ST_SOFT) && $past(sync_tick) && ($past(q.cnt) == 17'h00000))
		else $error("config pins resumed too soon");

	// General pins float and the hard reset pin is driven while power-on reset is low.
	por_hiz_a: assert property (!power_on_reset_n_i |=> io_hiz_o && hard_reset_oe_o)
		else $error("pins active during power-on reset");

	// DLL wait ends only after the ratio-based target.
	dll_wait_a: assert property ((q.st == ST_DLL) ##1 (q.st == ST_HARD) |->
		$past(q.cnt) >= $past(dll_end))
		else $error("dll wait cut short");

	// Each main edge in the DLL wait adds the PLL ratio.
	csb_step_a: assert property ((q.st == ST_DLL) && main_rise && (q.cnt < dll_end) |=>
		q.cnt == $past(q.cnt) + CNT_W'($past(pll_ratio_i)))
		else $error("bus cycle count wrong");

	// Agent mode ticks follow bus clock edges exactly.
	ref_sel_a: assert property (!host_mode_i |-> (sync_tick == bus_rise))
		else $error("wrong reference clock");

	// Straps are held once power-on reset is released.
	strap_hold_a: assert property ((q.st != ST_POR) |=> $stable(q.src_q) && $stable(q.div_q))
		else $error("straps changed after capture");

	// Main scenarios.
	full_seq_c: cover property ((q.st == ST_SOFT) ##1 (q.st == ST_RUN));
	ext_hard_c: cover property ((q.st == ST_RUN) ##1 (q.st == ST_HARD));
	ext_soft_c: cover property ((q.st == ST_RUN) ##1 (q.st == ST_SRST));
	div_host_c: cover property (host_mode_i && q.div_q && sync_tick);

endmodule

// [include/rsq_pkg.sv]
// ****************************************************************
// Reset sequencer constants and types.
// ****************************************************************
package rsq_pkg;

	// System clock period in ns (40 MHz).
	localparam int SYS_PERIOD_NS = 25;
	// Longest PLL lock time in ns, waited out in full.
	localparam int PLL_LOCK_NS   = 100000;
	// PLL lock wait in system cycles, rounded up.
	localparam int PLL_LOCK_CYC  = (PLL_LOCK_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	// Counter widths.
	localparam int CNT_W = 17;
	localparam int EXT_W = 6;

	// Intervals in bus synchronization clock periods.
	localparam logic [CNT_W-1:0] HARD_HOLD_TICKS  = 17'h00200; // 512
	localparam logic [CNT_W-1:0] SOFT_GAP_TICKS   = 17'h00010; // 16
	localparam logic [CNT_W-1:0] CFG_RESUME_TICKS = 17'h00001; // 1
	localparam logic [EXT_W-1:0] EXT_REQ_TICKS    = 6'h20;     // 32

	// DLL lock wait is DLL_BASE * ratio * ratio system bus cycles.
	localparam logic [CNT_W-1:0] DLL_BASE      = 17'h00780; // 1920
	localparam logic [3:0]       DLL_RATIO_MIN = 4'h2;
	localparam logic [3:0]       DLL_RATIO_MAX = 4'h8;
	localparam logic [CNT_W-1:0] PLL_LOCK_END  = CNT_W'(PLL_LOCK_CYC - 1);

	// Sequencer states, one-hot.
	typedef enum logic [6:0] {
		ST_POR  = 7'h01,
		ST_PLL  = 7'h02,
		ST_DLL  = 7'h04,
		ST_HARD = 7'h08,
		ST_SOFT = 7'h10,
		ST_SRST = 7'h20,
		ST_RUN  = 7'h40
	} rsq_state_t;

	// Complete state of the sequencer.
	typedef struct packed {
		rsq_state_t       st;
		logic [CNT_W-1:0] cnt;
		logic [EXT_W-1:0] ext;
		logic             main_q;
		logic             bus_q;
		logic             div_ph;
		logic [2:0]       src_q;
		logic             div_q;
		logic             cfg_en;
	} rsq_regs_t;

endpackage

// [test/rsq_board_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// Board reset controller and strap drivers.
// ****************************************************************
module rsq_board_model (
	input  wire logic       clk_i,       // System clock.
	input  wire logic       por_req_i,   // Request power-on reset.
	input  wire logic       hard_req_i,  // Pull hard reset pin low.
	input  wire logic       soft_req_i,  // Pull soft reset pin low.
	input  wire logic [2:0] src_i,       // Source strap value.
	input  wire logic       div_i,       // Divider strap value.
	input  wire logic       hard_oe_i,   // Device pulls hard pin.
	input  wire logic       soft_oe_i,   // Device pulls soft pin.
	output logic            main_clk_o,  // Main clock, period 2.
	output logic            bus_clk_o,   // Bus clock, period 8.
	output logic            por_n_o,     // Power-on reset level.
	output logic            hard_pin_o,  // Resolved hard pin.
	output logic            soft_pin_o,  // Resolved soft pin.
	output logic [2:0]      src_o,       // Source strap pins.
	output logic            div_o        // Divider strap pin.
);
	logic [8:0] por_cnt;  // Cycles since power-on request ended.
	logic [2:0] ph;       // Bus clock divider.

	initial
	begin
		main_clk_o = 1'b0;
		bus_clk_o  = 1'b0;
		por_n_o    = 1'b0;
		por_cnt    = 9'h000;
		ph         = 3'h0;
	end

	// Clocks run free; 300 cycles of power-on covers 32 of either clock.
	always @(negedge clk_i)
	begin
		main_clk_o <= ~main_clk_o;
		ph         <= ph + 3'h1;
		bus_clk_o  <= ph[2];
		if (por_req_i)
			por_cnt <= 9'h000;
		else if (por_cnt != 9'h12C)
			por_cnt <= por_cnt + 9'h001;
		por_n_o <= (por_cnt == 9'h12C) && !por_req_i;
	end

	// Pins are wired-AND with a pull-up.
	assign hard_pin_o = !(hard_oe_i || hard_req_i);
	assign soft_pin_o = !(soft_oe_i || soft_req_i);
	// Straps stand while hard reset is low, then show a wrong value.
	assign src_o = hard_pin_o ? ~src_i : src_i;
	assign div_o = hard_pin_o ? ~div_i : div_i;
endmodule

// [test/rsq_reset_seq_tb.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module rsq_reset_seq_tb;
	import rsq_pkg::*;
	logic       clk, rst_n, host, por_req, hard_req, soft_req, div;  // Bench drives.
	logic [2:0] src;                                                 // Strap value.
	logic       mclk, bclk, por_n, hpin, spin, sdiv, hn, hoe, sn, soe, cfg_oe, hiz, div_o, rdy;
	logic [2:0] ssrc, src_o;                                         // Straps in and out.
	logic [3:0] pll_r, dll_r;                                        // PLL and DLL ratios.
	int         bad_count, num_checks, cyc;                          // Counters.

	rsq_board_model board (.clk_i(clk), .por_req_i(por_req), .hard_req_i(hard_req),
		.soft_req_i(soft_req), .src_i(src), .div_i(div), .hard_oe_i(hoe), .soft_oe_i(soe),
		.main_clk_o(mclk), .bus_clk_o(bclk), .por_n_o(por_n), .hard_pin_o(hpin),
		.soft_pin_o(spin), .src_o(ssrc), .div_o(sdiv));

	rsq_reset_seq dut (.clk_sys_i(clk), .rst_n_i(rst_n), .host_mode_i(host),
		.main_clock_in_i(mclk), .bus_clock_in_i(bclk), .power_on_reset_n_i(por_n),
		.hard_reset_n_i(hpin), .soft_reset_n_i(spin), .strap_reset_source_i(ssrc),
		.strap_input_divider_i(sdiv), .pll_ratio_i(pll_r), .dll_ratio_i(dll_r),
		.hard_reset_n_o(hn), .hard_reset_oe_o(hoe), .soft_reset_n_o(sn), .soft_reset_oe_o(soe),
		.cfg_oe_o(cfg_oe), .io_hiz_o(hiz), .strap_reset_source_o(src_o),
		.strap_input_divider_o(div_o), .ready_o(rdy));

	// Reports the verdict and ends the run.
	task automatic finish_test();
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Selects an output to wait on.
	function automatic logic pick(input int s);
		return (s == 0) ? hoe : (s == 1) ? soe : rdy;
	endfunction

	// Waits at falling edges for a level, bounded so a hang shows.
	task automatic wait_lvl(input int s, input logic v, output int n);
		n = 0;
		while (pick(s) !== v && n < 20000)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	// Power-up; tick is the expected sync period in system cycles.
	task automatic power_up(input logic h, input logic d, input logic [2:0] s, input int tick);
		int n;
		int g;
		int e;
		@(negedge clk);
		host    = h;
		div     = d;
		src     = s;
		por_req = 1'b1;
		repeat (8) @(negedge clk);
		`CHK(hiz, 1'b1)
		`CHK(cfg_oe, 1'b0)
		por_req = 1'b0;
		wait_lvl(0, 1'b0, n);
		// Board power-on hold, PLL wait, DLL wait in main periods of two cycles, hard hold.
		e = int'(DLL_BASE) * int'(dll_r) * int'(dll_r);
		e = 300 + PLL_LOCK_CYC + 512 * tick + 2 * ((e + int'(pll_r) - 1) / int'(pll_r));
		`CHK(n >= e - tick - 2 && n <= e + 6, 1'b1)
		wait_lvl(1, 1'b0, g);
		`CHK(g > 15 * tick && g <= 17 * tick, 1'b1)
		wait_lvl(2, 1'b1, n);
		`CHK({src_o, div_o}, {s, d})
		`CHK({hn, sn, hoe, soe, hiz, cfg_oe}, 6'h01)
	endtask

	// Pin requests from the board in agent mode.
	task automatic ext_reset();
		int d;
		int n;
		@(negedge clk);
		hard_req = 1'b1;
		repeat (160) @(negedge clk);
		`CHK(cfg_oe, 1'b0)
		`CHK(hoe, 1'b0)
		hard_req = 1'b0;
		repeat (16) @(negedge clk);
		hard_req = 1'b1;
		d = 0;
		repeat (320)
		begin
			@(negedge clk);
			d += int'(hoe === 1'b1);
		end
		`CHK(hoe, 1'b1)
		hard_req = 1'b0;
		wait_lvl(0, 1'b0, n);
		`CHK(d + n > 4088 && d + n <= 4112, 1'b1)
		`CHK(cfg_oe, 1'b0)
		wait_lvl(2, 1'b1, n);
		`CHK(cfg_oe, 1'b1)
		soft_req = 1'b1;
		repeat (320) @(negedge clk);
		`CHK({hoe, soe}, 2'b01)
		soft_req = 1'b0;
		wait_lvl(2, 1'b1, n);
		`CHK(rdy, 1'b1)
		`CHK(n > 4016 && n <= 4040, 1'b1)
	endtask

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Cuts a hang short.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			finish_test();
		end
	end

	initial
	begin
		{rst_n, host, div, hard_req, soft_req} = 5'h00;
		por_req    = 1'b1;
		src        = 3'h0;
		bad_count  = 0;
		num_checks = 0;
		cyc        = 0;
		pll_r      = 4'hF;
		dll_r      = 4'h2;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		power_up(1'b0, 1'b0, 3'h5, 8);
		ext_reset();
		power_up(1'b1, 1'b0, 3'h2, 2);
		// A larger clock ratio lengthens the DLL wait.
		pll_r = 4'hC;
		dll_r = 4'h3;
		power_up(1'b1, 1'b1, 3'h6, 4);
		finish_test();
	end
endmodule
